// [verilog/sram_host.sv]
// Host controller that drives a 2048 x 8 asynchronous static memory
//
// Contract
// - Address stays constant through each whole read and write cycle.
// - Write strobe or chip select is high whenever the address changes.
// - Write happens only while chip select and write strobe are both low.
// - Data is held valid around the rising edge ending the write.
`timescale 1ns/100ps
`default_nettype none
`include "sram_host_cfg.svh"

module sram_host
  import srh_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqWrite,
  input  wire logic [10:0] reqAddr,
  input  wire logic [7:0]  reqData,
  output logic             rspValid,
  output logic [7:0]       rspData,
  output logic [10:0]      wordSelectLines,
  output logic             chipSelN,
  output logic             writeN,
  output logic             outEnN,
  input  wire logic [7:0]  sharedDataBusIn,
  output logic [7:0]       sharedDataBusOut,
  output logic             sharedDataBusOeN
);

  // ****************************************
  // Data bus synchroniser
  // ****************************************
  // The memory has no clock, so its bus is a pin input. Each bit runs
  // through three flops and only moves once stages two and three agree.
  // Trade-off: five extra cycles on every read, no metastable sample.
  wire [7:0]                busFilt;

  generate
    for (genvar bitIdx = 0; bitIdx < 8; bitIdx++)
    begin : g_busSync
      logic                 meta;
      logic                 mid;
      logic                 late;
      logic                 filt;
      logic                 next_meta;
      logic                 next_mid;
      logic                 next_late;
      logic                 next_filt;

      // Shift one stage, hold the filtered bit while the stages disagree
      always_comb
      begin
        next_meta = sharedDataBusIn[bitIdx];
        next_mid  = meta;
        next_late = mid;
        if (mid == late)
          next_filt = late;
        else
          next_filt = filt;
      end

      // Registers only
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          meta <= 1'b0;
          mid  <= 1'b0;
          late <= 1'b0;
          filt <= 1'b0;
        end
        else
        begin
          meta <= next_meta;
          mid  <= next_mid;
          late <= next_late;
          filt <= next_filt;
        end
      end

      assign busFilt[bitIdx] = filt;
    end
  endgenerate

  // ****************************************
  // Sequencer
  // ****************************************
  srh_state_e               state;
  srh_state_e               next_state;
  srh_pins_s                pins;
  srh_pins_s                next_pins;
  logic [`SRH_CNT_W-1:0]    cnt;
  logic [`SRH_CNT_W-1:0]    next_cnt;
  logic                     next_rspValid;
  logic [7:0]               next_rspData;

  // Access time plus synchroniser delay; 14 still fits the counter
  localparam logic [`SRH_CNT_W-1:0] RD_CNT  = `SRH_CNT_W'(`SRH_RD_SMP_CYC);
  localparam logic [`SRH_CNT_W-1:0] WP_CNT  = `SRH_CNT_W'(`SRH_WP_CYC);
  localparam logic [`SRH_CNT_W-1:0] DIS_CNT = `SRH_CNT_W'(`SRH_DIS_CYC);

  assign reqReady = (state == SRH_IDLE);

  // Next values of the pin group and the response
  always_comb
  begin
    next_state    = state;
    next_pins     = pins;
    next_cnt      = cnt;
    next_rspValid = 1'b0;
    next_rspData  = rspData;
    case (state)
      SRH_IDLE:
      begin
        // Address only moves here, with the strobe high; a read drops select on the same edge
        if (reqValid)
        begin
          next_pins.addr = reqAddr;
          if (reqWrite)
          begin
            // Drive data and drop output enable before the strobe
            next_pins.dataOut = reqData;
            next_pins.dataOe  = 1'b1;
            next_pins.outEnN  = 1'b1;
            next_state        = SRH_WSET;
          end
          else
          begin
            next_pins.chipSelN = 1'b0;
            next_pins.outEnN   = 1'b0;
            next_pins.writeN   = 1'b1;
            next_cnt           = RD_CNT;
            next_state         = SRH_RDACC;
          end
        end
      end
      SRH_RDACC:
      begin
        // Wait out access time and synchroniser, then sample the word
        if (cnt == `SRH_CNT_W'(1))
        begin
          next_rspData       = busFilt;
          next_rspValid      = 1'b1;
          next_pins.chipSelN = 1'b1;
          next_pins.outEnN   = 1'b1;
          next_cnt           = DIS_CNT;
          next_state         = SRH_TURN;
        end
        else
          next_cnt = cnt - `SRH_CNT_W'(1);
      end
      SRH_WSET:
      begin
        // Address settled one cycle ahead of the overlap
        next_pins.chipSelN = 1'b0;
        next_pins.writeN   = 1'b0;
        next_cnt           = WP_CNT;
        next_state         = SRH_WPULS;
      end
      SRH_WPULS:
      begin
        if (cnt == `SRH_CNT_W'(1))
        begin
          next_pins.writeN = 1'b1;
          next_state       = SRH_WEND;
        end
        else
          next_cnt = cnt - `SRH_CNT_W'(1);
      end
      SRH_WEND:
      begin
        // Data held one cycle past the strobe's rising edge
        next_pins.chipSelN = 1'b1;
        next_pins.dataOe   = 1'b0;
        next_rspValid      = 1'b1;
        next_state         = SRH_IDLE;
      end
      SRH_TURN:
      begin
        // Let the memory release the bus before anyone else drives it
        if (cnt == `SRH_CNT_W'(1))
          next_state = SRH_IDLE;
        else
          next_cnt = cnt - `SRH_CNT_W'(1);
      end
      default:
      begin
        next_state = SRH_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state    <= SRH_IDLE;
      pins     <= '{addr: 11'h000, chipSelN: 1'b1, writeN: 1'b1, outEnN: 1'b1,
                    dataOut: 8'h00, dataOe: 1'b0};
      cnt      <= '0;
      rspValid <= 1'b0;
      rspData  <= 8'h00;
    end
    else
    begin
      state    <= next_state;
      pins     <= next_pins;
      cnt      <= next_cnt;
      rspValid <= next_rspValid;
      rspData  <= next_rspData;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  assign wordSelectLines  = pins.addr;
  assign chipSelN         = pins.chipSelN;
  assign writeN           = pins.writeN;
  assign outEnN           = pins.outEnN;
  assign sharedDataBusOut = pins.dataOut;
  assign sharedDataBusOeN = ~pins.dataOe;  // Low while driving

endmodule
`default_nettype wire

// [verilog/sram_host_cfg.svh]
// Timing and geometry constants for the static memory host controller
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH

`define SRH_ADDR_W      11
`define SRH_DATA_W      8
`define SRH_CLK_PS      5000
// Slowest grade figures, in picoseconds
`define SRH_T_RD_CYC_PS 45000
`define SRH_T_WP_PS     40000
`define SRH_T_DIS_PS    25000
`define SRH_T_ACC_PS    45000
// Cycle counts, least times rounded up
`define SRH_RD_CYC  ((`SRH_T_ACC_PS + `SRH_CLK_PS - 1) / `SRH_CLK_PS)
`define SRH_WP_CYC  ((`SRH_T_WP_PS + `SRH_CLK_PS - 1) / `SRH_CLK_PS)
`define SRH_DIS_CYC ((`SRH_T_DIS_PS + `SRH_CLK_PS - 1) / `SRH_CLK_PS)
// Extra read wait for the data bus synchroniser: one late capture,
// three stages and the filter flop
`define SRH_SYNC_CYC   5
`define SRH_RD_SMP_CYC (`SRH_RD_CYC + `SRH_SYNC_CYC)
`define SRH_CNT_W   4

`endif

// [verilog/srh_pkg.sv]
// Types shared by the static memory host controller
`default_nettype none
package srh_pkg;
  typedef enum logic [2:0]
  {
    SRH_IDLE  = 3'b000,
    SRH_RDACC = 3'b001,
    SRH_WSET  = 3'b010,
    SRH_WPULS = 3'b011,
    SRH_WEND  = 3'b100,
    SRH_TURN  = 3'b101
  } srh_state_e;

  // Pin group driven towards the memory
  typedef struct packed
  {
    logic [10:0] addr;
    logic        chipSelN;
    logic        writeN;
    logic        outEnN;
    logic [7:0]  dataOut;
    logic        dataOe;
  } srh_pins_s;
endpackage
`default_nettype wire

// [testbench/srh_mem_model.sv]
// Behavioural 2048 x 8 static memory on the host pins
`timescale 1ns/100ps
`default_nettype none
module srh_mem_model (
  input wire logic [10:0] wordSelectLines,
  input wire logic        chipSelN,
  input wire logic        writeN,
  input wire logic        outEnN,
  input wire logic [7:0]  busLvl,
  output logic     [7:0]  memQ
);
  logic [7:0] mem [2048];
  logic [7:0] last;
  logic       drive;
  // Whichever strobe rises first ends the write
  always @(posedge writeN) if (!chipSelN) mem[wordSelectLines] <= busLvl;
  always @(posedge chipSelN) if (!writeN) mem[wordSelectLines] <= busLvl;
  assign drive = !chipSelN && writeN && !outEnN;
  // Floating bus shows the inverse, so a stale word never matches
  always @* if (drive) last = mem[wordSelectLines];
  assign memQ = drive ? mem[wordSelectLines] : ~last;
endmodule
`default_nettype wire

// [testbench/srh_host_sva.sv]
// Pin timing checker for the static memory host controller
`timescale 1ns/100ps
`default_nettype none
module srh_host_sva (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire logic        reqWrite,
  input wire logic        rspValid,
  input wire logic [10:0] wordSelectLines,
  input wire logic        chipSelN,
  input wire logic        writeN,
  input wire logic        outEnN,
  input wire logic [7:0]  sharedDataBusOut,
  input wire logic        sharedDataBusOeN
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RD_LAT: assert property (reqValid && reqReady && !reqWrite |-> ##[15:16] rspValid) else $error("read late");
  AST_WR_LAT: assert property (reqValid && reqReady && reqWrite |-> ##[11:12] rspValid) else $error("write late");
  AST_ADDR_RD: assert property (!chipSelN && $past(!chipSelN) |-> $stable(wordSelectLines)) else $error("addr");
  AST_ADDR_WR: assert property (!writeN |-> $stable(wordSelectLines)) else $error("addr in write");
  AST_WPULSE: assert property ($fell(writeN) |-> (!writeN && !chipSelN)[*8] ##1 writeN) else $error("pulse");
  AST_WHOLD: assert property ($rose(writeN) |-> !sharedDataBusOeN && $stable(sharedDataBusOut)) else $error("hold");
  AST_NOCLASH: assert property (!sharedDataBusOeN |-> outEnN) else $error("clash");
  AST_RDSEL: assert property (!outEnN |-> !chipSelN && writeN) else $error("read sel");
  AST_RDACC: assert property ($fell(outEnN) |-> (!outEnN)[*8]) else $error("access");
endmodule
bind sram_host srh_host_sva srh_host_sva_inst (.sys_clk, .rst, .reqValid, .reqReady, .reqWrite, .rspValid,
  .wordSelectLines, .chipSelN, .writeN, .outEnN, .sharedDataBusOut, .sharedDataBusOeN);
`default_nettype wire

// [testbench/sram_host_tb.sv]
// Self-checking bench for the static memory host controller
`timescale 1ns/100ps
`default_nettype none
module sram_host_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [10:0] reqAddr = 11'h000;
  logic [7:0]  reqData = 8'h00;
  logic        reqReady, rspValid, chipSelN, writeN, outEnN, oeN;
  logic [7:0]  rspData, busOut, memQ, busLvl;
  logic [10:0] wsl;
  int          n_fail = 0;
  int          compares = 0;
  // Clock and bus level: host wins only while enabled
  always #2.5 sys_clk = ~sys_clk;
  assign busLvl = oeN ? memQ : busOut;
  sram_host sram_host_inst (.sys_clk, .rst, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqData, .rspValid,
    .rspData, .wordSelectLines(wsl), .chipSelN, .writeN, .outEnN, .sharedDataBusIn(busLvl),
    .sharedDataBusOut(busOut), .sharedDataBusOeN(oeN));
  srh_mem_model srh_mem_model_inst (.wordSelectLines(wsl), .chipSelN, .writeN, .outEnN, .busLvl, .memQ);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One request, bounded waits for idle and answer
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
    int i;
    for (i = 0; reqReady !== 1'b1 && i < 40; i++) @(negedge sys_clk);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqData <= d;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    for (i = 0; rspValid !== 1'b1 && i < 40; i++) @(negedge sys_clk);
    if (i >= 40)
    begin
      n_fail++;
      $display("[FAIL] %0t no answer got %h exp %h", $time, rspValid, 1'b1);
    end
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rspData, e);
  endtask
  task automatic t_edges;
    xfer(1'b1, 11'h000, 8'hA5);
    xfer(1'b1, 11'h7FF, 8'h5A);
    rd(11'h000, 8'hA5);
    rd(11'h7FF, 8'h5A);
    $display("edges done");
  endtask
  // Walking address bit exposes any aliased line
  task automatic t_lines;
    for (int i = 0; i < 11; i++) xfer(1'b1, 11'h001 << i, 8'h30 + 8'(i));
    for (int i = 0; i < 11; i++) rd(11'h001 << i, 8'h30 + 8'(i));
    rd(11'h000, 8'hA5);
    $display("lines done");
  endtask
  task automatic t_over;
    xfer(1'b1, 11'h155, 8'hFF);
    xfer(1'b1, 11'h155, 8'h00);
    rd(11'h155, 8'h00);
    $display("overwrite done");
  endtask
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence after 10 reset cycles
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_edges;
    t_lines;
    t_over;
    end_sim;
  end
  // Watchdog, about eight times the expected run
  initial
  begin
    #20000;
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
